// file: bench/ccp_compare_pwm_unit_properties.sv
// Checker of bus handshake and trigger relations at the pair's ports
`timescale 1ns/1ps
`default_nettype none
module ccp_compare_pwm_unit_properties
    import ccp_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    input wire logic timer_a_reset_o,
    input wire logic timer_b_reset_o,
    input wire logic adc_start_o,
    input wire logic unit_one_match_flag_o,
    input wire logic unit_two_match_flag_o
);
    // Single domain, reset silences every check
    default clocking cb_main @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    property p_ready_after_setup;
        psel_i && !penable_i |=> pready_o && penable_i;
    endproperty
    a_ready_after_setup: assert property (p_ready_after_setup) else $error("no ready after setup");
    property p_ready_in_access;
        pready_o |-> psel_i && penable_i;
    endproperty
    a_ready_in_access: assert property (p_ready_in_access) else $error("ready outside access");
    property p_err_unmapped;
        psel_i && penable_i && pready_o && paddr_i > STATUS_ADDR |-> pslverr_o;
    endproperty
    a_err_unmapped: assert property (p_err_unmapped) else $error("unmapped access accepted");
    property p_upper_zero;
        pready_o && !pwrite_i |-> prdata_o[31:8] == 24'h000000;
    endproperty
    a_upper_zero: assert property (p_upper_zero) else $error("upper read bits not zero");
    property p_adc_with_reset;
        adc_start_o |-> timer_a_reset_o || timer_b_reset_o;
    endproperty
    a_adc_with_reset: assert property (p_adc_with_reset) else $error("start without trigger");
    property p_adc_with_flag;
        adc_start_o |=> unit_two_match_flag_o;
    endproperty
    a_adc_with_flag: assert property (p_adc_with_flag) else $error("start without flag");
    property p_reset_with_flag;
        timer_a_reset_o || timer_b_reset_o |=> unit_one_match_flag_o || unit_two_match_flag_o;
    endproperty
    a_reset_with_flag: assert property (p_reset_with_flag) else $error("clear without flag");
    property p_reset_pulse;
        $rose(timer_a_reset_o) |=> !timer_a_reset_o [*2];
    endproperty
    a_reset_pulse: assert property (p_reset_pulse) else $error("clear pulse repeated");
endmodule : ccp_compare_pwm_unit_properties
bind ccp_compare_pwm_unit ccp_compare_pwm_unit_properties ccp_compare_pwm_unit_properties_inst (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .timer_a_reset_o(timer_a_reset_o), .timer_b_reset_o(timer_b_reset_o),
    .adc_start_o(adc_start_o), .unit_one_match_flag_o(unit_one_match_flag_o),
    .unit_two_match_flag_o(unit_two_match_flag_o));
`default_nettype wire

// file: bench/ccp_compare_pwm_unit_tb.sv
// Self-checking bench of the compare/PWM pair with a reference model
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e, m) begin n_tests++; if ((a) !== (e)) begin n_mismatch++; \
    $display("wrong value at %0t: %s", $time, m); end end
module ccp_compare_pwm_unit_tb;
    import ccp_pkg::*;
    logic clk_i = 1'b0; // 40 MHz system clock
    logic rst_b_i = 1'b0; // Held low for 20 cycles
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, hold = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, er, rst_a, rst_b, adc, wrap;
    logic [1:0] pin, fl, fine;
    logic [1:0] port_c_direction = 2'b11; // Both pins start as inputs
    wire logic [1:0] pad; // Level seen at the pins, pulled high while inputs
    assign pad = pin | port_c_direction;
    logic [15:0] cnt_a, cnt_b;
    logic [7:0] cnt_c;
    int n_mismatch = 0, n_tests = 0, cyc = 0, n_ra = 0, n_rb = 0, n_adc = 0;
    int pin_m[2] = '{0, 0}, flag_m[2] = '{0, 0}, exp_ra = 0, exp_rb = 0, exp_adc = 0; // Model
    logic [3:0] modes[$] = '{MODE_TOGGLE, MODE_SET_LOW, MODE_SET_HIGH, MODE_SOFT_INT, MODE_SPECIAL};
    always #12.5 clk_i = ~clk_i;
    ccp_compare_pwm_unit ccp_compare_pwm_unit_inst (.clk_i(clk_i), .rst_b_i(rst_b_i),
        .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
        .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
        .timer_a_count_i(cnt_a), .timer_b_count_i(cnt_b), .timer_c_count_i(cnt_c),
        .timer_c_fine_i(fine), .timer_c_wrap_i(wrap), .unit_one_pin_o(pin[0]),
        .unit_two_pin_o(pin[1]), .timer_a_reset_o(rst_a), .timer_b_reset_o(rst_b),
        .adc_start_o(adc), .unit_one_match_flag_o(fl[0]), .unit_two_match_flag_o(fl[1]));
    ccp_timer_model ccp_timer_model_inst (.clk_i(clk_i), .rst_b_i(rst_b_i), .hold_i(hold),
        .reset_a_i(rst_a), .reset_b_i(rst_b), .count_a_o(cnt_a), .count_b_o(cnt_b),
        .count_c_o(cnt_c), .fine_o(fine), .wrap_o(wrap));
    // Verdict and end of run, shared with the watchdog
    task automatic complete_run;
        $display("mismatches %0d comparisons %0d", n_mismatch, n_tests);
        if (n_mismatch == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : complete_run
    // Pulse counters and watchdog; a hang counts as a mismatch
    always @(posedge clk_i) begin
        cyc++;
        n_ra += (rst_a === 1'b1);
        n_rb += (rst_b === 1'b1);
        n_adc += (adc === 1'b1);
        if (cyc == 20000) begin
            n_mismatch++;
            complete_run();
        end
    end
    // One APB transfer; the answer is taken at the edge where ready is seen
    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge clk_i);
        penable <= 1'b1;
        do @(posedge clk_i); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
        apb(1'b0, a, 8'h00);
        `CHK(rd, {24'h000000, e}, "read data")
    endtask : rdchk
    task automatic wait_phase(input logic [9:0] p);
        for (int k = 0; k < 200 && {cnt_c, fine} !== p; k++) @(negedge clk_i);
    endtask : wait_phase
    // One compare match in mode m on unit u, checked against the model
    task automatic run_case(input int u, input logic [3:0] m);
        logic [7:0] lo;
        logic [15:0] v;
        logic s, ae;
        lo = u ? CV2_LOW_ADDR : CV1_LOW_ADDR;
        s = 1'($urandom);
        ae = 1'($urandom);
        hold <= 1'b1; // Frozen timers cannot meet a half-written value
        apb(1'b1, STATUS_ADDR, 8'h03);
        flag_m = '{0, 0};
        apb(1'b1, CONFIG_ADDR, {5'h00, ae, s, s});
        v = (s ? cnt_b : cnt_a) + 16'(20 + $urandom % 40);
        apb(1'b1, lo, v[7:0]);
        apb(1'b1, lo + 8'h04, v[15:8]);
        rdchk(lo + 8'h04, v[15:8]);
        apb(1'b1, lo + 8'h08, {4'h0, m});
        if (m == MODE_SET_HIGH || m == MODE_SET_LOW) begin
            repeat (3) @(posedge clk_i);
            pin_m[u] = (m == MODE_SET_LOW);
            `CHK(pad[u], 1'(pin_m[u]), "pin start level")
        end
        hold <= 1'b0;
        if (m == MODE_TOGGLE) begin
            // Stop on the match value: a second toggle would show a rematch
            for (int k = 0; k < 200 && (s ? cnt_b : cnt_a) !== v - 16'h1; k++) @(negedge clk_i);
            @(posedge clk_i) hold <= 1'b1;
        end
        for (int k = 0; k < 200 && fl[u] !== 1'b1; k++) @(negedge clk_i);
        repeat (8) @(negedge clk_i);
        flag_m[u] = 1;
        case (m)
            MODE_TOGGLE: pin_m[u] = 1 - pin_m[u];
            MODE_SET_LOW: pin_m[u] = 0;
            MODE_SET_HIGH: pin_m[u] = 1;
            MODE_SPECIAL: begin
                exp_ra += 1 - s;
                exp_rb += s;
                exp_adc += (u == 1) && ae;
            end
            default: ;
        endcase
        `CHK(pad[u], 1'(pin_m[u]), "pin level")
        `CHK(n_ra, exp_ra, "timer a clears")
        `CHK(n_rb, exp_rb, "timer b clears")
        `CHK(n_adc, exp_adc, "converter starts")
        rdchk(STATUS_ADDR, {4'h0, 1'(pin_m[1]), 1'(pin_m[0]), 1'(flag_m[1]), 1'(flag_m[0])});
    endtask : run_case
    // Main sequence
    initial begin
        void'($urandom(32'hb596));
        repeat (20) @(posedge clk_i);
        rst_b_i <= 1'b1;
        port_c_direction <= 2'b00;
        rdchk(UNIT1_CTRL_ADDR, CTRL_RESET);
        rdchk(CONFIG_ADDR, CFG_RESET);
        rdchk(STATUS_ADDR, 8'h00);
        apb(1'b1, UNIT2_CTRL_ADDR, 8'hf3);
        rdchk(UNIT2_CTRL_ADDR, 8'h33);
        apb(1'b1, 8'h20, 8'hff);
        `CHK(er, 1'b1, "unmapped write")
        rdchk(8'h20, 8'h00);
        `CHK(er, 1'b1, "unmapped read")
        apb(1'b1, UNIT2_CTRL_ADDR, 8'h00);
        for (int u = 0; u < 2; u++) begin
            foreach (modes[i]) run_case(u, modes[i]);
            apb(1'b1, u ? UNIT2_CTRL_ADDR : UNIT1_CTRL_ADDR, 8'h00);
            pin_m[u] = 0;
            repeat (3) @(posedge clk_i);
            `CHK(pin[u], 1'b0, "zero write")
        end
        // PWM with duty 33 and low mode bits set
        apb(1'b1, CV1_LOW_ADDR, 8'h08);
        apb(1'b1, UNIT1_CTRL_ADDR, 8'h1f);
        wait_phase(10'd63);
        wait_phase(10'd6);
        `CHK(pin[0], 1'b1, "pwm rises on wrap")
        wait_phase(10'd40);
        `CHK(pin[0], 1'b0, "pwm falls on duty")
        wait_phase(10'd6);
        `CHK(pin[0], 1'b1, "pwm second period")
        apb(1'b1, UNIT1_CTRL_ADDR, 8'h00);
        repeat (2) @(posedge clk_i);
        `CHK(pin[0], 1'b0, "pwm latch cleared")
        complete_run();
    end
endmodule : ccp_compare_pwm_unit_tb
`default_nettype wire

// file: bench/ccp_timer_model.sv
// Behavioural model of the two compare time bases and the PWM timer
`timescale 1ns/1ps
`default_nettype none
module ccp_timer_model #(
    parameter logic [7:0] PERIOD = 8'h0f // Short period keeps runs brief
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic hold_i, // Freeze both compare timers
    input wire logic reset_a_i, // Trigger clear of timer a
    input wire logic reset_b_i, // Trigger clear of timer b
    output logic [15:0] count_a_o,
    output logic [15:0] count_b_o,
    output logic [7:0] count_c_o,
    output logic [1:0] fine_o,
    output logic wrap_o
);
    // Wrap marks the tick that leaves the period value
    assign wrap_o = (count_c_o == PERIOD) && (fine_o == 2'b11);
    // Timers step on the system clock only, never asynchronously
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            count_a_o <= 16'h0000;
            count_b_o <= 16'h8000; // Far from timer a, so a wrong select shows
        end else begin
            count_a_o <= reset_a_i ? 16'h0000 : count_a_o + {15'h0000, !hold_i};
            count_b_o <= reset_b_i ? 16'h0000 : count_b_o + {15'h0000, !hold_i};
        end
    end
    // PWM time base with two fine bits below the count
    always_ff @(posedge clk_i) begin
        if (!rst_b_i || wrap_o)
            {count_c_o, fine_o} <= 10'h000;
        else
            {count_c_o, fine_o} <= {count_c_o, fine_o} + 10'h001;
    end
endmodule : ccp_timer_model
`default_nettype wire

// file: hdl/ccp_compare_pwm_unit.sv
// Top of the compare/PWM pair with APB register access
`timescale 1ns/1ps
`default_nettype none
module ccp_compare_pwm_unit
    import ccp_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic [15:0] timer_a_count_i,
    input wire logic [15:0] timer_b_count_i,
    input wire logic [7:0] timer_c_count_i,
    input wire logic [1:0] timer_c_fine_i,
    input wire logic timer_c_wrap_i,
    output logic unit_one_pin_o,
    output logic unit_two_pin_o,
    output logic timer_a_reset_o,
    output logic timer_b_reset_o,
    output logic adc_start_o,
    output logic unit_one_match_flag_o,
    output logic unit_two_match_flag_o
);
    logic [7:0] compare_value_one_low;  // Unit one compare low byte
    logic [7:0] compare_value_one_high; // Unit one compare high byte
    logic [7:0] unit_one_control;       // Unit one control
    logic [7:0] compare_value_two_low;  // Unit two compare low byte
    logic [7:0] compare_value_two_high; // Unit two compare high byte
    logic [7:0] unit_two_control;       // Unit two control
    logic [7:0] config_reg;             // Timer selects and converter enable
    logic flag1_reg;                    // Unit one match flag
    logic flag2_reg;                    // Unit two match flag
    logic wr_en;                        // Write taken this edge
    logic rd_en;                        // Read taken this edge
    logic addr_ok;                      // Address is mapped
    logic [31:0] rd_mux;                // Read data selection
    ccp_unit_if u1 ();
    ccp_unit_if u2 ();

    // Zero-wait APB: access phase always completes
    assign wr_en = psel_i && penable_i && pwrite_i;
    assign rd_en = psel_i && penable_i && !pwrite_i;
    assign addr_ok = (paddr_i == CV1_LOW_ADDR) || (paddr_i == CV1_HIGH_ADDR) ||
                     (paddr_i == UNIT1_CTRL_ADDR) || (paddr_i == CV2_LOW_ADDR) ||
                     (paddr_i == CV2_HIGH_ADDR) || (paddr_i == UNIT2_CTRL_ADDR) ||
                     (paddr_i == CONFIG_ADDR) || (paddr_i == STATUS_ADDR);

    // Register writes; control bits above the mode and duty fields stay zero
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            compare_value_one_low <= 8'h00;
            compare_value_one_high <= 8'h00;
            unit_one_control <= CTRL_RESET;
            compare_value_two_low <= 8'h00;
            compare_value_two_high <= 8'h00;
            unit_two_control <= CTRL_RESET;
            config_reg <= CFG_RESET;
        end else if (wr_en) begin
            unique case (paddr_i)
                CV1_LOW_ADDR: compare_value_one_low <= pwdata_i[7:0];
                CV1_HIGH_ADDR: begin
                    // High byte is read-only while PWM mode is selected; the duty comes from the low byte
                    if (unit_one_control[MODE_MSB:MODE_MSB-1] != MODE_PWM_TOP) begin
                        compare_value_one_high <= pwdata_i[7:0];
                    end
                end
                UNIT1_CTRL_ADDR: unit_one_control <= pwdata_i[7:0] & CTRL_WRITE_MASK;
                CV2_LOW_ADDR: compare_value_two_low <= pwdata_i[7:0];
                CV2_HIGH_ADDR: begin
                    if (unit_two_control[MODE_MSB:MODE_MSB-1] != MODE_PWM_TOP) begin
                        compare_value_two_high <= pwdata_i[7:0];
                    end
                end
                UNIT2_CTRL_ADDR: unit_two_control <= pwdata_i[7:0] & CTRL_WRITE_MASK;
                CONFIG_ADDR: config_reg <= pwdata_i[7:0] & 8'h07;
                default: config_reg <= config_reg;
            endcase
        end
    end

    // Unit wiring
    assign u1.ctrl = unit_one_control;
    assign u1.value = {compare_value_one_high, compare_value_one_low};
    assign u1.count = config_reg[CFG_TSEL1_BIT] ? timer_b_count_i : timer_a_count_i;
    assign u1.period_cnt = timer_c_count_i;
    assign u1.fine = timer_c_fine_i;
    assign u1.period_wrap = timer_c_wrap_i;
    assign u1.ctrl_zero_wr = wr_en && (paddr_i == UNIT1_CTRL_ADDR) &&
                             ((pwdata_i[7:0] & CTRL_WRITE_MASK) == 8'h00);
    assign u2.ctrl = unit_two_control;
    assign u2.value = {compare_value_two_high, compare_value_two_low};
    assign u2.count = config_reg[CFG_TSEL2_BIT] ? timer_b_count_i : timer_a_count_i;
    assign u2.period_cnt = timer_c_count_i;
    assign u2.fine = timer_c_fine_i;
    assign u2.period_wrap = timer_c_wrap_i;
    assign u2.ctrl_zero_wr = wr_en && (paddr_i == UNIT2_CTRL_ADDR) &&
                             ((pwdata_i[7:0] & CTRL_WRITE_MASK) == 8'h00);

    ccp_unit unit_one (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .u(u1)
    );
    ccp_unit unit_two (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .u(u2)
    );

    // Match flags: hardware set wins over a write-one clear in the same cycle
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            flag1_reg <= 1'b0;
            flag2_reg <= 1'b0;
        end else begin
            if (u1.match) begin
                flag1_reg <= 1'b1;
            end else if (wr_en && paddr_i == STATUS_ADDR && pwdata_i[STAT_FLAG1_BIT]) begin
                flag1_reg <= 1'b0;
            end
            if (u2.match) begin
                flag2_reg <= 1'b1;
            end else if (wr_en && paddr_i == STATUS_ADDR && pwdata_i[STAT_FLAG2_BIT]) begin
                flag2_reg <= 1'b0;
            end
        end
    end

    // Timer reset and converter start pulses; these are a separate path from
    // timer overflow, so the timer's own flag is never raised by them
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            timer_a_reset_o <= 1'b0;
            timer_b_reset_o <= 1'b0;
            adc_start_o <= 1'b0;
        end else begin
            timer_a_reset_o <= (u1.special && !config_reg[CFG_TSEL1_BIT]) ||
                               (u2.special && !config_reg[CFG_TSEL2_BIT]);
            timer_b_reset_o <= (u1.special && config_reg[CFG_TSEL1_BIT]) ||
                               (u2.special && config_reg[CFG_TSEL2_BIT]);
            adc_start_o <= u2.special && config_reg[CFG_ADC_EN_BIT];
        end
    end

    // Pins and flags mirrored onto registered outputs
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            unit_one_pin_o <= 1'b0;
            unit_two_pin_o <= 1'b0;
            unit_one_match_flag_o <= 1'b0;
            unit_two_match_flag_o <= 1'b0;
        end else begin
            unit_one_pin_o <= u1.pin;
            unit_two_pin_o <= u2.pin;
            unit_one_match_flag_o <= flag1_reg;
            unit_two_match_flag_o <= flag2_reg;
        end
    end

    // Read data selection
    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (paddr_i)
            CV1_LOW_ADDR: rd_mux[7:0] = compare_value_one_low;
            CV1_HIGH_ADDR: rd_mux[7:0] = compare_value_one_high;
            UNIT1_CTRL_ADDR: rd_mux[7:0] = unit_one_control;
            CV2_LOW_ADDR: rd_mux[7:0] = compare_value_two_low;
            CV2_HIGH_ADDR: rd_mux[7:0] = compare_value_two_high;
            UNIT2_CTRL_ADDR: rd_mux[7:0] = unit_two_control;
            CONFIG_ADDR: rd_mux[7:0] = config_reg;
            STATUS_ADDR: rd_mux[3:0] = {u2.pin, u1.pin, flag2_reg, flag1_reg};
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // APB answer registered: pready is high in the access phase's first cycle
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o <= 32'h0000_0000;
        end else begin
            pready_o <= psel_i && !penable_i;
            pslverr_o <= psel_i && !penable_i && !addr_ok;
            if (psel_i && !penable_i && !pwrite_i) begin
                prdata_o <= rd_mux;
            end
        end
    end
endmodule : ccp_compare_pwm_unit
`default_nettype wire

// file: hdl/ccp_pkg.sv
// Package with register map, field layout and mode codes of the compare/PWM pair
package ccp_pkg;
    // Register byte addresses on the APB bus
    localparam logic [7:0] CV1_LOW_ADDR = 8'h00;
    localparam logic [7:0] CV1_HIGH_ADDR = 8'h04;
    localparam logic [7:0] UNIT1_CTRL_ADDR = 8'h08;
    localparam logic [7:0] CV2_LOW_ADDR = 8'h0c;
    localparam logic [7:0] CV2_HIGH_ADDR = 8'h10;
    localparam logic [7:0] UNIT2_CTRL_ADDR = 8'h14;
    localparam logic [7:0] CONFIG_ADDR = 8'h18;
    localparam logic [7:0] STATUS_ADDR = 8'h1c;
    // Control register fields
    localparam int MODE_LSB = 0;
    localparam int MODE_MSB = 3;
    localparam int DUTY_FINE_LSB = 4;
    localparam int DUTY_FINE_MSB = 5;
    localparam logic [7:0] CTRL_WRITE_MASK = 8'h3f;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    // Config register fields (timer select per unit, converter enable)
    localparam int CFG_TSEL1_BIT = 0;
    localparam int CFG_TSEL2_BIT = 1;
    localparam int CFG_ADC_EN_BIT = 2;
    localparam logic [7:0] CFG_RESET = 8'h00;
    // Status register fields (match flags, pin levels; write one to clear flags)
    localparam int STAT_FLAG1_BIT = 0;
    localparam int STAT_FLAG2_BIT = 1;
    localparam int STAT_PIN1_BIT = 2;
    localparam int STAT_PIN2_BIT = 3;
    // Mode codes
    localparam logic [3:0] MODE_OFF = 4'h0;
    localparam logic [3:0] MODE_TOGGLE = 4'h2;
    localparam logic [3:0] MODE_SET_HIGH = 4'h8;
    localparam logic [3:0] MODE_SET_LOW = 4'h9;
    localparam logic [3:0] MODE_SOFT_INT = 4'ha;
    localparam logic [3:0] MODE_SPECIAL = 4'hb;
    localparam logic [1:0] MODE_PWM_TOP = 2'b11;
    // Fine bit counter width for the PWM duty extension
    localparam int FINE_BITS = 2;
endpackage : ccp_pkg

// file: hdl/ccp_unit.sv
// One compare/PWM unit: match detect, pin action, PWM latch
`timescale 1ns/1ps
`default_nettype none
module ccp_unit
    import ccp_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_b_i,
    ccp_unit_if.unit u
);
    logic [3:0] mode;          // Mode bits of this unit
    logic eq_now;              // Count equals compare value
    logic eq_reg;              // Equality seen last cycle
    logic is_pwm;              // PWM selected
    logic is_compare;          // Compare mode selected
    logic [9:0] duty_reg;      // Latched PWM duty
    logic [9:0] duty_next;     // Duty staged by software
    logic [9:0] pwm_count;     // Third timer count with fine bits
    logic prev_pwm;            // PWM mode last cycle
    logic [3:0] prev_mode;     // Mode bits last cycle, to notice a mode change

    assign mode = u.ctrl[MODE_MSB:MODE_LSB];
    assign is_pwm = (mode[3:2] == MODE_PWM_TOP);
    assign is_compare = (mode == MODE_TOGGLE) || (mode == MODE_SET_HIGH) ||
                        (mode == MODE_SET_LOW) || (mode == MODE_SOFT_INT) ||
                        (mode == MODE_SPECIAL);
    assign eq_now = (u.count == u.value);
    assign duty_next = {u.value[7:0], u.ctrl[DUTY_FINE_MSB:DUTY_FINE_LSB]};
    assign pwm_count = {u.period_cnt, u.fine};

    // Equality history so a held count matches only once
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            eq_reg <= 1'b0;
        end else begin
            eq_reg <= eq_now;
        end
    end

    // Match pulse on the first equal cycle only
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            u.match <= 1'b0;
            u.special <= 1'b0;
        end else begin
            u.match <= is_compare && eq_now && !eq_reg;
            u.special <= (mode == MODE_SPECIAL) && eq_now && !eq_reg;
        end
    end

    // PWM and mode history, to notice entry to PWM or to a drive mode
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            prev_pwm <= 1'b0;
            prev_mode <= MODE_OFF;
        end else begin
            prev_pwm <= is_pwm;
            prev_mode <= mode;
        end
    end

    // Double-buffered duty, reloaded at each period wrap
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            duty_reg <= 10'h000;
        end else if (is_pwm && (u.period_wrap || !prev_pwm)) begin
            duty_reg <= duty_next;
        end
    end

    // Output latch; a match acts in the same cycle as the flag is raised
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            u.pin <= 1'b0;
        end else if (u.ctrl_zero_wr || mode == MODE_OFF) begin
            u.pin <= 1'b0;
        end else if (is_pwm) begin
            if (u.period_wrap) begin
                u.pin <= (duty_next != 10'h000);
            end else if (pwm_count == duty_reg) begin
                u.pin <= 1'b0;
            end
        end else if (u.match) begin
            // Registered match keeps the pin action on the flag's edge
            unique case (mode)
                MODE_TOGGLE: u.pin <= ~u.pin;
                MODE_SET_HIGH: u.pin <= 1'b1;
                MODE_SET_LOW: u.pin <= 1'b0;
                default: u.pin <= u.pin;
            endcase
        end else if (mode != prev_mode && (mode == MODE_SET_HIGH || mode == MODE_SET_LOW)) begin
            // Entering a drive mode sets the opposite starting level
            u.pin <= (mode == MODE_SET_LOW);
        end
    end
endmodule : ccp_unit
`default_nettype wire

// file: hdl/ccp_unit_if.sv
// Interface carrying one unit's configuration in and events out
`timescale 1ns/1ps
`default_nettype none
interface ccp_unit_if;
    logic [7:0] ctrl;       // Unit control register
    logic [15:0] value;     // Compare value (high:low)
    logic [15:0] count;     // Selected timer count
    logic [7:0] period_cnt; // Third timer count
    logic [1:0] fine;       // Fine bits for PWM
    logic period_wrap;      // Third timer wraps this cycle
    logic ctrl_zero_wr;     // Whole control written to zero
    logic match;            // One cycle match event
    logic special;          // Special event trigger pulse
    logic pin;              // Output latch level
    modport top (output ctrl, value, count, period_cnt, fine, period_wrap, ctrl_zero_wr,
                 input match, special, pin);
    modport unit (input ctrl, value, count, period_cnt, fine, period_wrap, ctrl_zero_wr,
                  output match, special, pin);
endinterface : ccp_unit_if
`default_nettype wire
